// ==== bench/status_output_selector_sva.sv ====
// port-level checks for the status output selector
`timescale 1ns/100ps
module status_output_selector_sva
  import status_output_selector_pkg::*;
(
  input wire logic                clk_sys,
  input wire logic                reset,
  input wire logic [ADDR_W-1:0]   regAddr,
  input wire logic [DATA_W-1:0]   regWdata,
  input wire logic                regWrite,
  input wire logic                regRead,
  input wire logic [DATA_W-1:0]   regRdata,
  input wire logic [15:0]         maintenance_timer_count,
  input wire logic                tripEvent,
  input wire logic                faultReset,
  input wire logic                fanFail,
  input wire logic                commWarn,
  input wire logic [NUM_TERM-1:0] terminalConduct
);
  logic [15:0] sel0Sh, sel1Sh, sel2Sh, thrSh;
  logic [2:0]  remSh;

  // shadow of the writable codes, so checks follow software changes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sel0Sh <= RST_SEL0;
      sel1Sh <= RST_SEL1;
      sel2Sh <= RST_SEL2;
      thrSh  <= RST_MAINT_THR;
      remSh  <= RST_REMOTE;
    end else if (regWrite) begin
      if (regAddr == OFS_SEL0) sel0Sh <= regWdata;
      if (regAddr == OFS_SEL1) sel1Sh <= regWdata;
      if (regAddr == OFS_REMOTE) remSh <= regWdata[2:0];
      if (regAddr == OFS_MAINT_THR) thrSh <= regWdata;
      // pulse codes never reach the relay shadow
      if (regAddr == OFS_SEL2 && regWdata != CODE_PULSE_POS &&
          regWdata != CODE_PULSE_NEG) sel2Sh <= regWdata;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_read_one_cycle: assert property (!regRead |=> regRdata == '0)
    else $error("read data outside its cycle");
  a_relay_code_kept: assert property (
    regRead && regAddr == OFS_SEL2 |=> regRdata == $past(sel2Sh))
    else $error("relay code readback wrong");
  a_run_code_default: assert property (
    regRead && regAddr == OFS_SEL0 |=> regRdata == $past(sel0Sh))
    else $error("running terminal code readback wrong");
  a_trip_reaches_relay: assert property (
    tripEvent && !regWrite && sel2Sh == 16'h0063
    |-> ##2 terminalConduct[2])
    else $error("trip did not reach relay");
  a_trip_holds: assert property (
    sel2Sh == 16'h0063 && $past(sel2Sh) == 16'h0063 &&
    terminalConduct[2] && !$past(faultReset) |=> terminalConduct[2])
    else $error("trip dropped without fault reset");
  a_fault_reset_clears: assert property (
    faultReset && !tripEvent && !regWrite && sel2Sh == 16'h0063
    |-> ##2 !terminalConduct[2])
    else $error("relay still on after fault reset");
  a_remote_follows: assert property (
    (sel0Sh == 16'h0060 && !regWrite) [*3]
    |-> terminalConduct[0] == remSh[0])
    else $error("remote terminal not following its bit");
  a_maint_level: assert property (
    (sel1Sh == 16'h005F && !regWrite &&
     $stable(maintenance_timer_count)) [*3]
    |-> terminalConduct[1] == (maintenance_timer_count >= thrSh))
    else $error("maintenance output wrong");
  a_light_level: assert property (
    (sel1Sh == 16'h0062 && !regWrite && $stable({fanFail, commWarn})) [*3]
    |-> terminalConduct[1] == (fanFail | commWarn))
    else $error("light warning output wrong");
  a_same_function: assert property (
    (sel0Sh == sel1Sh && sel0Sh != 16'h0060 && !regWrite) [*3]
    |-> terminalConduct[0] == terminalConduct[1])
    else $error("terminals with one code disagree");
endmodule

// ==== bench/status_output_selector_tb_top.sv ====
// self-checking bench for the status output selector
`timescale 1ns/100ps
module status_output_selector_tb_top
  import status_output_selector_pkg::*;
;
  logic              clk_sys = 1'b0;
  logic              reset = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWdata = '0;
  logic [DATA_W-1:0] regRdata;
  logic              regWrite = 1'b0;
  logic              regRead = 1'b0;
  logic              powerUpDone = 1'b0;
  logic              powerFail = 1'b0;
  logic              dcBrake = 1'b0;
  logic              coasting = 1'b0;
  logic              rampTimeZero = 1'b0;
  logic              tripEvent = 1'b0;
  logic              faultReset = 1'b0;
  logic              fanFail = 1'b0;
  logic              commWarn = 1'b0;
  logic              output_shutoff_input = 1'b0;
  logic [15:0]       outputFrequency = '0;
  logic [15:0]       targetFrequency = '0;
  logic [15:0]       avgCurrent = '0;
  logic [15:0]       maintenance_timer_count = '0;
  tripCause_s        tripCause = '0;
  lifeWarn_s         lifeWarn = '0;
  logic [NUM_TERM-1:0] terminalConduct;
  logic [NUM_TERM-1:0] lineHigh;
  int                miscompares = 0;
  int                check_count = 0;

  // short pulse frames keep the averaged-current scenario brief
  status_output_selector #(.PULSE_W(4)) status_output_selector_inst (
    .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .powerUpDone(powerUpDone),
    .powerFail(powerFail), .dcBrake(dcBrake), .coasting(coasting),
    .rampTimeZero(rampTimeZero), .outputFrequency(outputFrequency),
    .targetFrequency(targetFrequency), .avgCurrent(avgCurrent),
    .maintenance_timer_count(maintenance_timer_count),
    .tripEvent(tripEvent), .tripCause(tripCause),
    .faultReset(faultReset), .lifeWarn(lifeWarn), .fanFail(fanFail),
    .commWarn(commWarn), .output_shutoff_input(output_shutoff_input),
    .terminalConduct(terminalConduct));

  terminal_load_model terminal_load_model_inst (
    .terminalConduct(terminalConduct), .lineHigh(lineHigh));

  // free-running system clock
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string n, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask

  // terminal i seen on its line: conducting means the line is low
  task automatic tm(input int i, input logic e, input string n);
    chk(n, {15'h0000, ~e}, {15'h0000, lineHigh[i]});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e,
                    input string n);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 chk(n, e, regRdata);
  endtask

  // drive state {powerup, powerfail, dcbrake, coast, shutoff}, frequency
  task automatic step(input logic [4:0] c, input logic [15:0] f,
                      input logic run, rdy, input string n);
    @(posedge clk_sys);
    {powerUpDone, powerFail, dcBrake, coasting, output_shutoff_input} <= c;
    outputFrequency <= f;
    settle(6);
    tm(0, run, n);
    tm(1, rdy, n);
  endtask

  task automatic trip(input logic [7:0] c);
    @(posedge clk_sys);
    tripEvent <= 1'b1;
    tripCause <= c;
    @(posedge clk_sys);
    tripEvent <= 1'b0;
    settle(8);
  endtask

  task automatic clear;
    @(posedge clk_sys) faultReset <= 1'b1;
    @(posedge clk_sys) faultReset <= 1'b0;
    settle(4);
  endtask

  // running on the default terminal, ready on terminal 1
  task automatic t_ready_run;
    wr(OFS_SEL1, 16'h000B);
    step(5'b00000, 16'h0000, 1'b0, 1'b0, "before powerup");
    step(5'b10000, 16'h0000, 1'b0, 1'b1, "stopped");
    step(5'b10000, 16'h0031, 1'b0, 1'b1, "below start");
    step(5'b10000, 16'h0032, 1'b1, 1'b1, "at start");
    step(5'b10100, 16'h0032, 1'b0, 1'b1, "dc brake");
    step(5'b10010, 16'h0032, 1'b0, 1'b1, "coasting");
    step(5'b11010, 16'h0032, 1'b0, 1'b0, "undervolt");
    step(5'b10001, 16'h0032, 1'b0, 1'b0, "shutoff");
    step(5'b10000, 16'h0032, 1'b1, 1'b1, "restart");
  endtask

  task automatic t_trip;
    trip(8'h01);
    tm(0, 1'b0, "run on trip");
    tm(1, 1'b0, "ready on trip");
    clear();
    wr(OFS_SEL0, 16'h00C7);
    wr(OFS_SEL1, 16'h005B);
    for (int i = 0; i < 8; i++) begin
      trip(8'h01 << i);
      tm(0, 1'b0, "trip negative");
      tm(1, i != 0, "power fault");
      tm(2, 1'b1, "relay trip");
      clear();
      tm(0, 1'b1, "negative idle");
      tm(1, 1'b0, "power fault idle");
      tm(2, 1'b0, "relay idle");
    end
  endtask

  task automatic t_pulse;
    int hi;
    wr(OFS_SEL2, CODE_PULSE_POS);
    wr(OFS_SEL2, CODE_PULSE_NEG);
    rd(OFS_SEL2, RST_SEL2, "relay code kept");
    wr(OFS_SEL0, CODE_PULSE_POS);
    rd(OFS_SEL0, CODE_PULSE_POS, "open collector pulse code");
    @(posedge clk_sys);
    avgCurrent <= 16'h8000;
    maintenance_timer_count <= 16'h4000;
    settle(4);
    hi = 0;
    // one full current frame plus one maintenance frame
    repeat (32) begin
      @(posedge clk_sys);
      #1 hi += int'(!lineHigh[0]);
    end
    chk("pulse cycles", 16'h000C, 16'(hi));
  endtask

  task automatic t_levels;
    wr(OFS_SEL0, 16'h0060);
    wr(OFS_SEL1, 16'h0060);
    wr(OFS_REMOTE, 16'h0002);
    settle(3);
    tm(0, 1'b0, "remote bit 0");
    tm(1, 1'b1, "remote bit 1");
    wr(OFS_SEL1, 16'h005F);
    wr(OFS_MAINT_THR, 16'h4001);
    settle(3);
    tm(1, 1'b0, "maint below");
    wr(OFS_MAINT_THR, 16'h4000);
    settle(3);
    tm(1, 1'b1, "maint equal");
    wr(OFS_SEL0, 16'h0062);
    wr(OFS_SEL1, 16'h0062);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys) {fanFail, commWarn} <= 2'(k);
      settle(3);
      tm(0, k != 0, "light t0");
      tm(1, k != 0, "light t1");
    end
    wr(OFS_SEL1, 16'h00BE);
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_sys) lifeWarn <= lifeWarn_s'(4'h1 << k);
      settle(3);
      tm(1, k == 4, "life alarm");
    end
    wr(OFS_SEL0, CODE_NONE);
    settle(3);
    tm(0, 1'b0, "no function");
  endtask

  // reached flag on terminal 1 for one ramp setting and output frequency
  task automatic rch(input logic z, input logic [15:0] f, input logic e,
                     input string n);
    @(posedge clk_sys);
    rampTimeZero    <= z;
    outputFrequency <= f;
    settle(3);
    tm(1, e, n);
  endtask

  // a ramping frequency may chatter; zero ramp time must hold steady
  task automatic t_reached;
    wr(OFS_SEL1, 16'h0001);
    @(posedge clk_sys) targetFrequency <= 16'h0100;
    rch(1'b0, 16'h0100, 1'b1, "reached");
    rch(1'b0, 16'h00F0, 1'b0, "ramping");
    rch(1'b1, 16'h00F0, 1'b1, "zero ramp");
    rch(1'b1, 16'h0110, 1'b1, "zero ramp step");
  endtask

  // reset in mid-run restores the default codes and idles the terminals
  task automatic t_reset;
    @(posedge clk_sys) reset <= 1'b1;
    settle(2);
    chk("conduct in reset", 16'h0000, {13'h0000, terminalConduct});
    @(posedge clk_sys) reset <= 1'b0;
    rd(OFS_SEL2, RST_SEL2, "relay code after reset");
    rd(OFS_MAINT_THR, RST_MAINT_THR, "threshold after reset");
    settle(2);
    tm(0, 1'b1, "running after reset");
    tm(2, 1'b0, "relay after reset");
  endtask

  task automatic results;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    rd(OFS_SEL0, RST_SEL0, "run default");
    rd(OFS_SEL2, RST_SEL2, "relay default");
    rd(8'h20, 16'h0000, "unmapped read");
    t_ready_run();
    t_trip();
    t_pulse();
    t_levels();
    t_reached();
    t_reset();
    results();
  end

  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    results();
  end
endmodule

bind status_output_selector status_output_selector_sva
  status_output_selector_sva_inst (
  .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .maintenance_timer_count(maintenance_timer_count),
  .tripEvent(tripEvent), .faultReset(faultReset), .fanFail(fanFail),
  .commWarn(commWarn), .terminalConduct(terminalConduct));

// ==== bench/terminal_load_model.sv ====
// external equipment on the terminals: a pull-up on every output line
`timescale 1ns/100ps
module terminal_load_model
  import status_output_selector_pkg::*;
(
  input  wire logic [NUM_TERM-1:0] terminalConduct,
  output logic      [NUM_TERM-1:0] lineHigh
);
  // a conducting terminal pulls its line low; the relay gets the same
  // treatment from this load as the other terminals
  assign lineHigh = ~terminalConduct;
endmodule

// ==== inc/status_output_selector_pkg.sv ====
// constants, register map and carrier types for the status output selector
package status_output_selector_pkg;

  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // register byte offsets
  localparam logic [7:0] OFS_SEL0       = 8'h00;
  localparam logic [7:0] OFS_SEL1       = 8'h04;
  localparam logic [7:0] OFS_SEL2       = 8'h08;
  localparam logic [7:0] OFS_REMOTE     = 8'h0C;
  localparam logic [7:0] OFS_START_FREQ = 8'h10;
  localparam logic [7:0] OFS_MAINT_THR  = 8'h14;
  localparam logic [7:0] OFS_STATUS     = 8'h18;
  localparam logic [7:0] OFS_MAINT_CNT  = 8'h1C;

  // selection codes
  localparam logic [15:0] CODE_NEG_BASE = 16'h0064; // 100
  localparam logic [15:0] CODE_NEG_MAX  = 16'h00C7; // 199
  localparam logic [15:0] CODE_NONE     = 16'h270F; // 9999
  localparam logic [6:0] FN_RUN     = 7'h00;
  localparam logic [6:0] FN_REACHED = 7'h01;
  localparam logic [6:0] FN_READY   = 7'h0B;
  localparam logic [6:0] FN_LIFE    = 7'h5A;
  localparam logic [6:0] FN_PWRFLT  = 7'h5B;
  localparam logic [6:0] FN_PULSE   = 7'h5D;
  localparam logic [6:0] FN_MAINT   = 7'h5F;
  localparam logic [6:0] FN_REMOTE  = 7'h60;
  localparam logic [6:0] FN_LIGHT   = 7'h62;
  localparam logic [6:0] FN_TRIP    = 7'h63;
  localparam logic [15:0] CODE_PULSE_POS = 16'h005D; // 93
  localparam logic [15:0] CODE_PULSE_NEG = 16'h00C1; // 193

  // reset values
  localparam logic [15:0] RST_SEL0       = 16'h0000; // running, positive
  localparam logic [15:0] RST_SEL1       = 16'h0004; // frequency detect
  localparam logic [15:0] RST_SEL2       = 16'h0063; // fault trip, relay
  localparam logic [2:0]  RST_REMOTE     = 3'h0;
  localparam logic [15:0] RST_START_FREQ = 16'h0032;
  localparam logic [15:0] RST_MAINT_THR  = 16'hFFFF;

  // terminal count: two open-collector, one relay (last)
  localparam int NUM_TERM  = 3;
  localparam int RELAY_IDX = 2;

  // internal status functions shared by every terminal
  typedef struct packed {
    logic running;
    logic reached;
    logic ready;
    logic life;
    logic powerFault;
    logic pulse;
    logic maint;
    logic light;
    logic trip;
  } statusFlags_s;

  // cause of a fault trip, given together with the trip event
  typedef struct packed {
    logic brakeTransistor;
    logic groundFault;
    logic phaseLoss;
    logic paramStorage;
    logic internalBoard;
    logic processor;
    logic inrushCircuit;
    logic other;
  } tripCause_s;

  // component wear warnings
  typedef struct packed {
    logic ctrlCapacitor;
    logic mainCapacitor;
    logic inrushCircuit;
    logic coolingFan;
  } lifeWarn_s;

endpackage

// ==== rtl/current_pulse_gen.sv ====
// averaged-current pulse train: current frame then maintenance frame
`timescale 1ns/100ps
module current_pulse_gen #(
  parameter int VAL_W = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [VAL_W-1:0] avgCurrent,
  input  wire logic [VAL_W-1:0] maintValue,
  output logic                  pulse
);

  typedef struct packed {
    logic             phase;
    logic [VAL_W-1:0] count;
    logic             pulse;
  } state_s;

  state_s state;
  state_s next_state;
  logic [VAL_W-1:0] value;

  // pulse width inside each frame is proportional to the encoded value
  always_comb begin
    next_state = state;
    value = state.phase ? maintValue : avgCurrent;
    next_state.count = state.count + VAL_W'(1);
    if (&state.count) begin
      next_state.phase = ~state.phase;
    end
    next_state.pulse = (state.count < value);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pulse = state.pulse;

endmodule

// ==== rtl/status_output_selector.sv ====
// status output selector: status generation, register file, terminals
`timescale 1ns/100ps
module status_output_selector
  import status_output_selector_pkg::*;
#(
  parameter int PULSE_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  // register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [DATA_W-1:0] regRdata,
  // drive control state, same clock
  input  wire logic              powerUpDone,
  input  wire logic              powerFail,
  input  wire logic              dcBrake,
  input  wire logic              coasting,
  input  wire logic              rampTimeZero,
  input  wire logic [15:0]       outputFrequency,
  input  wire logic [15:0]       targetFrequency,
  input  wire logic [15:0]       avgCurrent,
  input  wire logic [15:0]       maintenance_timer_count,
  input  wire logic              tripEvent,
  input  wire tripCause_s        tripCause,
  input  wire logic              faultReset,
  input  wire lifeWarn_s         lifeWarn,
  input  wire logic              fanFail,
  input  wire logic              commWarn,
  // pin, asynchronous to clk_sys
  input  wire logic              output_shutoff_input,
  // terminals: bits 0 and 1 open collector, bit 2 relay contact
  output logic [NUM_TERM-1:0]    terminalConduct
);

  typedef struct packed {
    logic [15:0]          sel0;
    logic [15:0]          sel1;
    logic [15:0]          sel2;
    logic [NUM_TERM-1:0]  software_driven_output;
    logic [15:0]          starting_frequency_setting;
    logic [15:0]          maintenance_alarm_threshold;
    logic [DATA_W-1:0]    rdata;
    logic                 shutSync1;
    logic                 shutSync2;
    logic                 fault_trip_flag;
    logic                 power_circuit_fault_flag;
    logic                 drive_ready_flag;
    logic                 runningFlag;
    logic                 reached_frequency_flag;
    logic                 life_alarm_flag;
    logic                 maintenance_timer_flag;
    logic                 light_warning_flag;
    logic                 refusedWrite;
  } state_s;

  state_s state;
  state_s next_state;
  statusFlags_s flags;
  logic [15:0] selCode [NUM_TERM];
  logic pulseOut;
  logic circuitCause;
  logic shutoff;
  logic isPulseCode;

  assign selCode[0] = state.sel0;
  assign selCode[1] = state.sel1;
  assign selCode[2] = state.sel2;
  assign shutoff = state.shutSync2;

  // faults that come from the drive's own circuitry or its wiring
  assign circuitCause = tripCause.brakeTransistor
                      | tripCause.groundFault
                      | tripCause.phaseLoss
                      | tripCause.paramStorage
                      | tripCause.internalBoard
                      | tripCause.processor
                      | tripCause.inrushCircuit;

  assign isPulseCode = (regWdata == CODE_PULSE_POS)
                     | (regWdata == CODE_PULSE_NEG);

  // status generation, register writes and registered read answer
  always_comb begin
    next_state = state;

    // pin passes two flops; only the second one is read
    next_state.shutSync1 = output_shutoff_input;
    next_state.shutSync2 = state.shutSync1;

    // a trip in the same cycle as a reset wins, so no trip is lost
    next_state.fault_trip_flag = tripEvent
                               | (state.fault_trip_flag & ~faultReset);
    next_state.power_circuit_fault_flag =
        (tripEvent & circuitCause)
      | (state.power_circuit_fault_flag & ~faultReset);

    // ready: power-up done, not tripped, not shut off, supply healthy;
    // coasting alone does not clear it
    next_state.drive_ready_flag = powerUpDone
                                & ~state.fault_trip_flag
                                & ~tripEvent
                                & ~shutoff
                                & ~powerFail;

    // running also implies ready, since it needs the same conditions
    next_state.runningFlag =
        (outputFrequency >= state.starting_frequency_setting)
      & ~dcBrake
      & ~coasting
      & ~state.fault_trip_flag
      & ~tripEvent
      & ~shutoff
      & ~powerFail
      & powerUpDone;

    // with zero ramp time the flag is forced on without comparing to the
    // target, unless dc brake or zero output frequency, so it cannot chatter
    if (rampTimeZero) begin
      next_state.reached_frequency_flag = 1'b1;
    end else begin
      next_state.reached_frequency_flag =
          (outputFrequency == targetFrequency);
    end
    if (dcBrake | (outputFrequency == 16'h0000)) begin
      next_state.reached_frequency_flag = 1'b0;
    end

    next_state.life_alarm_flag = |lifeWarn;
    next_state.maintenance_timer_flag =
        (maintenance_timer_count >= state.maintenance_alarm_threshold);
    next_state.light_warning_flag = fanFail | commWarn;

    // register writes; pulse codes on the relay keep the old code
    if (regWrite) begin
      case (regAddr)
        OFS_SEL0: begin
          next_state.sel0 = regWdata;
        end
        OFS_SEL1: begin
          next_state.sel1 = regWdata;
        end
        OFS_SEL2: begin
          if (isPulseCode) begin
            next_state.refusedWrite = 1'b1;
          end else begin
            next_state.sel2 = regWdata;
            next_state.refusedWrite = 1'b0;
          end
        end
        OFS_REMOTE: begin
          next_state.software_driven_output = regWdata[NUM_TERM-1:0];
        end
        OFS_START_FREQ: begin
          next_state.starting_frequency_setting = regWdata;
        end
        OFS_MAINT_THR: begin
          next_state.maintenance_alarm_threshold = regWdata;
        end
        default: begin
          next_state.refusedWrite = state.refusedWrite;
        end
      endcase
    end

    // read answer stands for exactly the cycle after the strobe
    next_state.rdata = '0;
    if (regRead) begin
      case (regAddr)
        OFS_SEL0:       next_state.rdata = state.sel0;
        OFS_SEL1:       next_state.rdata = state.sel1;
        OFS_SEL2:       next_state.rdata = state.sel2;
        OFS_REMOTE:     next_state.rdata =
                          {13'h0000, state.software_driven_output};
        OFS_START_FREQ: next_state.rdata = state.starting_frequency_setting;
        OFS_MAINT_THR:  next_state.rdata = state.maintenance_alarm_threshold;
        OFS_STATUS:     next_state.rdata = {
                          5'h00,
                          state.refusedWrite,
                          shutoff,
                          state.light_warning_flag,
                          state.maintenance_timer_flag,
                          state.life_alarm_flag,
                          state.reached_frequency_flag,
                          state.power_circuit_fault_flag,
                          state.fault_trip_flag,
                          state.runningFlag,
                          state.drive_ready_flag,
                          pulseOut};
        OFS_MAINT_CNT:  next_state.rdata = maintenance_timer_count;
        default:        next_state.rdata = '0;
      endcase
    end
  end

  // register stage; defaults give running and fault trip their terminals
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state                             <= '0;
      state.sel0                        <= RST_SEL0;
      state.sel1                        <= RST_SEL1;
      state.sel2                        <= RST_SEL2;
      state.software_driven_output      <= RST_REMOTE;
      state.starting_frequency_setting  <= RST_START_FREQ;
      state.maintenance_alarm_threshold <= RST_MAINT_THR;
    end else begin
      state <= next_state;
    end
  end

  // shared flag bundle seen by every terminal
  always_comb begin
    flags.running    = state.runningFlag;
    flags.reached    = state.reached_frequency_flag;
    flags.ready      = state.drive_ready_flag | state.runningFlag;
    flags.life       = state.life_alarm_flag;
    flags.powerFault = state.power_circuit_fault_flag;
    flags.pulse      = pulseOut;
    flags.maint      = state.maintenance_timer_flag;
    flags.light      = state.light_warning_flag;
    flags.trip       = state.fault_trip_flag;
  end

  // pulse format uses the upper value bits; resolution traded for rate
  current_pulse_gen #(
    .VAL_W (PULSE_W)
  ) u_pulse (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .avgCurrent (avgCurrent[15 -: PULSE_W]),
    .maintValue (maintenance_timer_count[15 -: PULSE_W]),
    .pulse      (pulseOut)
  );

  // relay contact wear is the user's concern; nothing here slows it down
  genvar t;
  generate
    for (t = 0; t < NUM_TERM; t++) begin : g_term
      terminal_driver u_term (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .selCode   (selCode[t]),
        .flags     (flags),
        .remoteBit (state.software_driven_output[t]),
        .conduct   (terminalConduct[t])
      );
    end
  endgenerate

  assign regRdata = state.rdata;

endmodule

// ==== rtl/terminal_driver.sv ====
// one output terminal: code decode, polarity and registered drive
`timescale 1ns/100ps
module terminal_driver
  import status_output_selector_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic [15:0]  selCode,
  input  wire statusFlags_s flags,
  input  wire logic         remoteBit,
  output logic              conduct
);

  typedef struct packed {
    logic conduct;
  } state_s;

  state_s state;
  state_s next_state;
  logic [6:0] fnIndex;
  logic active;

  // each terminal decodes its own code, so one function may feed many
  always_comb begin
    next_state = state;
    fnIndex = selCode[6:0];
    if (selCode >= CODE_NEG_BASE) begin
      fnIndex = 7'(selCode - CODE_NEG_BASE);
    end
    case (fnIndex)
      FN_RUN:     active = flags.running;
      FN_REACHED: active = flags.reached;
      FN_READY:   active = flags.ready;
      FN_LIFE:    active = flags.life;
      FN_PWRFLT:  active = flags.powerFault;
      FN_PULSE:   active = flags.pulse;
      FN_MAINT:   active = flags.maint;
      FN_REMOTE:  active = remoteBit;
      FN_LIGHT:   active = flags.light;
      FN_TRIP:    active = flags.trip;
      default:    active = 1'b0;
    endcase
    if (selCode > CODE_NEG_MAX) begin
      next_state.conduct = 1'b0;
    end else if (selCode >= CODE_NEG_BASE) begin
      next_state.conduct = ~active;
    end else begin
      next_state.conduct = active;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign conduct = state.conduct;

endmodule
